// >>> inc/dpm_defines.vh
// Constants for the DiffServ priority map block.
// Assumes inclusion by bare name from the logic files.
`ifndef DPM_DEFINES_VH
`define DPM_DEFINES_VH

// ==========================================================
// Bus geometry
`define DPM_ADDR_W        12
`define DPM_DATA_W        32
`define DPM_IDX_W         7

// ==========================================================
// Map geometry
`define DPM_MAP_BITS      128
`define DPM_FIELD_W       2
`define DPM_CODE_W        6
`define DPM_CODE_MSB      7
`define DPM_CODE_LSB      2
`define DPM_SLOT_W        4

// ==========================================================
// Register indices; byte address is four times the index
`define DPM_PRIO_MAP_0_IDX 7'h60
`define DPM_PRIO_MAP_1_IDX 7'h61
`define DPM_PRIO_MAP_2_IDX 7'h62
`define DPM_PRIO_MAP_3_IDX 7'h63
`define DPM_MAP_IDX_FIRST  7'h60
`define DPM_MAP_IDX_LAST   7'h6f
`define DPM_CTRL_IDX       7'h70
`define DPM_LAST_IDX       7'h71
`define DPM_HITCNT_IDX     7'h72
`define DPM_BYPCNT_IDX     7'h73

// ==========================================================
// Reset values and fields
`define DPM_MAP_RESET     128'h0
`define DPM_CTRL_W        3
`define DPM_CTRL_RESET    3'h1
`define DPM_CTRL_EN_BIT   0
`define DPM_CTRL_DEF_MSB  2
`define DPM_CTRL_DEF_LSB  1
`define DPM_CNT_W         16

`endif

// >>> logic/dpm_lookup.v
// Field selector: one 2-bit priority out of the 128-bit map.
// Assumes a code already cut from the TOS byte; purely combinational.
`include "dpm_defines.vh"

module dpm_lookup (
  mapBits,
  code,
  field
);
  input  wire [`DPM_MAP_BITS-1:0] mapBits;
  input  wire [`DPM_CODE_W-1:0]   code;
  output reg  [`DPM_FIELD_W-1:0]  field;

  // ========================================================
  // Decode
  // Each code owns bits {code,0} upward, code 0 lowest
  wire [`DPM_CODE_W:0] bitBase;
  assign bitBase = {code, 1'b0};

  always @* begin
    field = mapBits[bitBase +: `DPM_FIELD_W];
  end
endmodule

// >>> logic/dpm_map_top.v
// DiffServ priority map: APB register bank plus two-stage frame classifier.
// Assumes APB master and classifier both run on sys_clk.
`include "dpm_defines.vh"

module dpm_map_top (
  sys_clk,
  arst_n,
  ce,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  pstrb,
  prdata,
  pready,
  pslverr,
  clsValid,
  clsIsIp,
  clsTos,
  prioValid,
  prioOut,
  prioMapped
);
  input  wire                     sys_clk;
  input  wire                     arst_n;
  input  wire                     ce;
  input  wire                     psel;
  input  wire                     penable;
  input  wire                     pwrite;
  input  wire [`DPM_ADDR_W-1:0]   paddr;
  input  wire [`DPM_DATA_W-1:0]   pwdata;
  input  wire [3:0]               pstrb;
  output reg  [`DPM_DATA_W-1:0]   prdata;
  output reg                      pready;
  output reg                      pslverr;
  input  wire                     clsValid;
  input  wire                     clsIsIp;
  input  wire [7:0]               clsTos;
  output reg                      prioValid;
  output reg  [`DPM_FIELD_W-1:0]  prioOut;
  output reg                      prioMapped;

  // ========================================================
  // Address helpers
  function [`DPM_IDX_W-1:0] regIndex;
    input [`DPM_ADDR_W-1:0] addr;
    begin
      regIndex = addr[`DPM_IDX_W+1:2];
    end
  endfunction

  function isMapIdx;
    input [`DPM_IDX_W-1:0] idx;
    begin
      isMapIdx = (idx >= `DPM_MAP_IDX_FIRST) &&
                 (idx <= `DPM_MAP_IDX_LAST);
    end
  endfunction

  // Unaligned or high addresses are unmapped
  function addrMapped;
    input [`DPM_ADDR_W-1:0] addr;
    reg   [`DPM_IDX_W-1:0]  idx;
    begin
      idx = addr[`DPM_IDX_W+1:2];
      if (addr[1:0] != 2'h0) begin
        addrMapped = 1'b0;
      end else if (addr[`DPM_ADDR_W-1:`DPM_IDX_W+2] != 3'h0) begin
        addrMapped = 1'b0;
      end else if (isMapIdx(idx)) begin
        addrMapped = 1'b1;
      end else if (idx == `DPM_CTRL_IDX) begin
        addrMapped = 1'b1;
      end else if (idx == `DPM_LAST_IDX) begin
        addrMapped = 1'b1;
      end else if (idx == `DPM_HITCNT_IDX) begin
        addrMapped = 1'b1;
      end else if (idx == `DPM_BYPCNT_IDX) begin
        addrMapped = 1'b1;
      end else begin
        addrMapped = 1'b0;
      end
    end
  endfunction

  // ========================================================
  // State
  reg [`DPM_MAP_BITS-1:0] map_reg;
  reg [`DPM_MAP_BITS-1:0] map_next;
  reg [`DPM_CTRL_W-1:0]   ctrl_reg;
  reg [`DPM_CTRL_W-1:0]   ctrl_next;
  reg [`DPM_CODE_W-1:0]   lastCode_reg;
  reg [`DPM_FIELD_W-1:0]  lastPrio_reg;
  reg                     lastMapped_reg;
  reg [`DPM_CNT_W-1:0]    hitCnt_reg;
  reg [`DPM_CNT_W-1:0]    hitCnt_next;
  reg [`DPM_CNT_W-1:0]    bypCnt_reg;
  reg [`DPM_CNT_W-1:0]    bypCnt_next;
  reg                     s1Valid_reg;
  reg                     s1IsIp_reg;
  reg [`DPM_CODE_W-1:0]   s1Code_reg;
  reg [`DPM_DATA_W-1:0]   rdMux;

  wire [`DPM_IDX_W-1:0]   idx;
  wire                    mapped;
  wire                    accDone;
  wire                    wrDone;
  wire                    pready_next;
  wire [`DPM_FIELD_W-1:0] fieldSel;
  wire                    useMap;
  wire                    hitEv;
  wire                    bypEv;
  wire [`DPM_SLOT_W-1:0]  slot;
  wire [`DPM_FIELD_W-1:0] defPrio;

  assign idx     = regIndex(paddr);
  assign mapped  = addrMapped(paddr);
  assign slot    = idx[`DPM_SLOT_W-1:0];
  assign defPrio = ctrl_reg[`DPM_CTRL_DEF_MSB:`DPM_CTRL_DEF_LSB];

  // ========================================================
  // APB handshake
  // One wait state: ready rises on the second access cycle
  assign pready_next = psel & penable & ~pready;
  assign accDone     = psel & penable & pready;
  assign wrDone      = accDone & pwrite & mapped & pstrb[0];

  // ========================================================
  // Map and control writes
  // sixteen byte slots
  always @* begin
    map_next  = map_reg;
    ctrl_next = ctrl_reg;
    if (wrDone && isMapIdx(idx)) begin
      map_next[{slot, 3'h0} +: 8] = pwdata[7:0];
    end else if (wrDone && (idx == `DPM_CTRL_IDX)) begin
      ctrl_next = pwdata[`DPM_CTRL_W-1:0];
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      map_reg  <= `DPM_MAP_RESET;
      ctrl_reg <= `DPM_CTRL_RESET;
    end else if (ce) begin
      map_reg  <= map_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // ========================================================
  // Read mux
  // fields read back
  always @* begin
    rdMux = {`DPM_DATA_W{1'b0}};
    if (isMapIdx(idx)) begin
      rdMux[7:0] = map_reg[{slot, 3'h0} +: 8];
    end else if (idx == `DPM_CTRL_IDX) begin
      rdMux[`DPM_CTRL_W-1:0] = ctrl_reg;
    end else if (idx == `DPM_LAST_IDX) begin
      rdMux[`DPM_CODE_W-1:0] = lastCode_reg;
      rdMux[9:8]             = lastPrio_reg;
      rdMux[16]              = lastMapped_reg;
    end else if (idx == `DPM_HITCNT_IDX) begin
      rdMux[`DPM_CNT_W-1:0] = hitCnt_reg;
    end else if (idx == `DPM_BYPCNT_IDX) begin
      rdMux[`DPM_CNT_W-1:0] = bypCnt_reg;
    end
  end

  // Data and error sampled with ready; zero outside a response
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= {`DPM_DATA_W{1'b0}};
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= pready_next;
      if (pready_next) begin
        prdata  <= (!pwrite && mapped) ? rdMux : {`DPM_DATA_W{1'b0}};
        pslverr <= ~mapped;
      end else begin
        prdata  <= {`DPM_DATA_W{1'b0}};
        pslverr <= 1'b0;
      end
    end
  end

  // ========================================================
  // Classifier stage 1: capture the code
  // upper six TOS bits
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1Valid_reg <= 1'b0;
      s1IsIp_reg  <= 1'b0;
      s1Code_reg  <= {`DPM_CODE_W{1'b0}};
    end else if (ce) begin
      s1Valid_reg <= clsValid;
      if (clsValid) begin
        s1IsIp_reg <= clsIsIp;
        s1Code_reg <= clsTos[`DPM_CODE_MSB:`DPM_CODE_LSB];
      end
    end
  end

  dpm_lookup u_lookup (
    .mapBits (map_reg),
    .code    (s1Code_reg),
    .field   (fieldSel)
  );

  assign useMap = s1IsIp_reg & ctrl_reg[`DPM_CTRL_EN_BIT];
  assign hitEv  = s1Valid_reg & useMap;
  assign bypEv  = s1Valid_reg & ~useMap;

  // ========================================================
  // Classifier stage 2: priority out
  // Map change lands on the frame result one cycle after the write edge
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prioValid      <= 1'b0;
      prioOut        <= {`DPM_FIELD_W{1'b0}};
      prioMapped     <= 1'b0;
      lastCode_reg   <= {`DPM_CODE_W{1'b0}};
      lastPrio_reg   <= {`DPM_FIELD_W{1'b0}};
      lastMapped_reg <= 1'b0;
    end else if (ce) begin
      prioValid <= s1Valid_reg;
      if (s1Valid_reg) begin
        prioOut        <= useMap ? fieldSel : defPrio;
        prioMapped     <= useMap;
        lastCode_reg   <= s1Code_reg;
        lastPrio_reg   <= useMap ? fieldSel : defPrio;
        lastMapped_reg <= useMap;
      end
    end
  end

  // ========================================================
  // Statistics
  // A write clears; a same-cycle event still counts after it
  always @* begin
    hitCnt_next = hitCnt_reg;
    bypCnt_next = bypCnt_reg;
    if (wrDone && (idx == `DPM_HITCNT_IDX)) begin
      hitCnt_next = {`DPM_CNT_W{1'b0}};
    end
    if (wrDone && (idx == `DPM_BYPCNT_IDX)) begin
      bypCnt_next = {`DPM_CNT_W{1'b0}};
    end
    // Saturate rather than wrap
    if (hitEv && (hitCnt_next != {`DPM_CNT_W{1'b1}})) begin
      hitCnt_next = hitCnt_next + 16'h0001;
    end
    if (bypEv && (bypCnt_next != {`DPM_CNT_W{1'b1}})) begin
      bypCnt_next = bypCnt_next + 16'h0001;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hitCnt_reg <= {`DPM_CNT_W{1'b0}};
      bypCnt_reg <= {`DPM_CNT_W{1'b0}};
    end else if (ce) begin
      hitCnt_reg <= hitCnt_next;
      bypCnt_reg <= bypCnt_next;
    end
  end
endmodule

// >>> sim/dpm_map_chk.sv
// Assertion checker for the DiffServ priority map top.
// Assumes one clock domain; bound onto every instance of the top.
`include "dpm_defines.vh"
module dpm_map_chk (
  input wire logic                    sys_clk,
  input wire logic                    arst_n,
  input wire logic                    ce,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`DPM_ADDR_W-1:0]  paddr,
  input wire logic [`DPM_DATA_W-1:0]  prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    clsValid,
  input wire logic                    clsIsIp,
  input wire logic                    prioValid,
  input wire logic [`DPM_FIELD_W-1:0] prioOut,
  input wire logic                    prioMapped
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ============================================
  // Classifier path
  a_prio_two_edges: assert property (
    clsValid && ce ##1 ce |=> prioValid)
    else $error("frame result not two edges after capture");
  a_nonip_default: assert property (
    clsValid && ce && !clsIsIp ##1 ce |=> !prioMapped)
    else $error("frame without IP header used the map");
  a_prio_holds: assert property ($changed(prioOut) |-> prioValid)
    else $error("priority changed without a result pulse");
  // ============================================
  // Register bus
  a_ready_delay: assert property (
    psel && !penable && ce ##1 ce |=> pready)
    else $error("bus answer not two cycles after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  a_ready_access: assert property (pready |-> $past(psel && penable))
    else $error("ready outside an access phase");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data nonzero outside ready");
  a_err_unaligned: assert property (
    pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  a_map_clean: assert property (
    pready && paddr[11:6] == 6'h06 && paddr[1:0] == 2'h0
    |-> !pslverr && prdata[31:8] == 24'h0)
    else $error("map register refused or upper bits set");
  c_ip_frame: cover property (prioValid && prioMapped);
  c_default: cover property (prioValid && !prioMapped);
  c_refused: cover property (pready && pslverr);
endmodule

bind dpm_map_top dpm_map_chk u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .clsValid(clsValid),
  .clsIsIp(clsIsIp), .prioValid(prioValid), .prioOut(prioOut),
  .prioMapped(prioMapped)
);

// >>> sim/tb.sv
// Self-checking bench for the DiffServ priority map top.
// Assumes the checker is bound in from its own file.
`include "dpm_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, arst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic        clsValid, clsIsIp, prioValid, prioMapped, rdErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [3:0]  pstrb;
  logic [7:0]  clsTos;
  logic [1:0]  prioOut;
  int          errCount, comparisons;

  dpm_map_top DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clsValid(clsValid), .clsIsIp(clsIsIp), .clsTos(clsTos),
    .prioValid(prioValid), .prioOut(prioOut), .prioMapped(prioMapped)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ============================================
  // Reporting
  task summarize;
    if (errCount == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chkReg(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("BAD reg at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task chkPrio(input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("BAD prio at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ============================================
  // Drivers; answers taken at the rising edge that samples them high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errCount++;
      summarize();
    end else begin
      rdVal = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task frame(input logic ip, input logic [7:0] tos, input logic [2:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    clsValid <= 1'b1;
    clsIsIp <= ip;
    clsTos <= tos;
    @(posedge sys_clk);
    clsValid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (prioValid !== 1'b1 && n < 8);
    if (prioValid !== 1'b1) begin
      errCount++;
      summarize();
    end else begin
      chkPrio({prioMapped, prioOut}, exp);
    end
  endtask

  // Distinct byte per map register so a swapped field shows up
  function automatic logic [7:0] pat(input int k);
    return 8'(k * 29 + 75);
  endfunction

  function automatic logic [1:0] fld(input int c);
    return 2'(pat(c / 4) >> (2 * (c % 4)));
  endfunction

  // ============================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    clsValid = 1'b0;
    clsIsIp = 1'b0;
    clsTos = 8'h0;
    errCount = 0;
    comparisons = 0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      xfer(1'b0, 12'(12'h180 + 4 * k), 32'h0);
      chkReg({rdErr, rdVal}, 33'h0);
    end
    xfer(1'b0, 12'h1c0, 32'h0);
    chkReg({rdErr, rdVal}, 33'h1);
    frame(1'b1, 8'h14, 3'h4);
    for (int k = 0; k < 16; k++) begin
      xfer(1'b1, 12'(12'h180 + 4 * k), {24'hffffff, pat(k)});
      xfer(1'b0, 12'(12'h180 + 4 * k), 32'h0);
      chkReg({rdErr, rdVal}, {25'h0, pat(k)});
    end
    // Low two TOS bits vary too; they must not affect the code
    for (int c = 0; c < 64; c++)
      frame(1'b1, {6'(c), 2'(c)}, {1'b1, fld(c)});
    xfer(1'b1, 12'h18c, 32'hc0);
    frame(1'b1, 8'h3c, 3'h7);
    frame(1'b1, 8'h33, 3'h4);
    xfer(1'b1, 12'h1c0, 32'h5);
    frame(1'b0, 8'h3c, 3'h2);
    xfer(1'b1, 12'h1c0, 32'h6);
    frame(1'b1, 8'h3c, 3'h3);
    xfer(1'b0, 12'h1c4, 32'h0);
    chkReg({rdErr, rdVal}, 33'h30f);
    xfer(1'b0, 12'h1c8, 32'h0);
    chkReg({rdErr, rdVal}, 33'h43);
    xfer(1'b0, 12'h1cc, 32'h0);
    chkReg({rdErr, rdVal}, 33'h2);
    xfer(1'b1, 12'h1c4, 32'hff);
    chkReg({rdErr, rdVal}, 33'h0);
    xfer(1'b1, 12'h1c8, 32'h0);
    xfer(1'b0, 12'h1c8, 32'h0);
    chkReg({rdErr, rdVal}, 33'h0);
    // Frozen clock enable must hold the result back
    fork
      frame(1'b1, 8'h3c, 3'h3);
      begin
        repeat (2) @(posedge sys_clk);
        ce <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chkPrio({2'b0, prioValid}, 3'h0);
        ce <= 1'b1;
      end
    join
    // Write without the low byte strobe stores nothing
    pstrb <= 4'he;
    xfer(1'b1, 12'h18c, 32'h3f);
    pstrb <= 4'hf;
    xfer(1'b0, 12'h18c, 32'h0);
    chkReg({rdErr, rdVal}, 33'hc0);
    xfer(1'b0, 12'h181, 32'h0);
    chkReg({rdErr, rdVal}, {1'b1, 32'h0});
    xfer(1'b1, 12'h200, 32'hff);
    chkReg({rdErr, rdVal}, {1'b1, 32'h0});
    // Second reset in mid-run must clear the map again
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    xfer(1'b0, 12'h18c, 32'h0);
    chkReg({rdErr, rdVal}, 33'h0);
    xfer(1'b0, 12'h1c0, 32'h0);
    chkReg({rdErr, rdVal}, 33'h1);
    summarize();
  end
endmodule
